// ---- common/hkadc_cfg.svh ----
// Purpose: Addresses, field positions, codes and timing of the housekeeping converter sequencer.
// Assumes: Register port addresses are the 8-bit special function register addresses.
// Notes: Definitions only.
`ifndef HKADC_CFG_SVH
`define HKADC_CFG_SVH

// ****************************************
// Register addresses
// ****************************************
`define HKADC_ADDR_TEMP_RESULT 8'hd7
`define HKADC_ADDR_START 8'hd8
`define HKADC_ADDR_BAT_RESULT 8'hdf
`define HKADC_ADDR_PM_ENABLE 8'hec
`define HKADC_ADDR_VSW_RESULT 8'hef
`define HKADC_ADDR_DELTA 8'hf3
`define HKADC_ADDR_PM_FLAGS 8'hf8
`define HKADC_ADDR_INTERVAL 8'hf9
`define HKADC_ADDR_BAT_THRESH 8'hfa

// ****************************************
// Channel numbers, also the start bit positions
// ****************************************
`define HKADC_CH_BAT 0
`define HKADC_CH_TEMP 1
`define HKADC_CH_VSW 2
`define HKADC_START_MASK 8'h07

// ****************************************
// Field layouts and reset values
// ****************************************
`define HKADC_PER_W 2
`define HKADC_DIFF_W 3
`define HKADC_DIFF_VSW_LSB 0
`define HKADC_DIFF_TEMP_LSB 3
`define HKADC_DIFF_NEVER 3'h0
`define HKADC_DIFF_ALWAYS 3'h7
`define HKADC_FLAG_VSW_BIT 0
`define HKADC_FLAG_BAT_BIT 1
`define HKADC_FLAG_MASK 8'h03
`define HKADC_REG_RESET 8'h00
`define HKADC_INTERVAL_CODE1 8'h01
`define HKADC_INTERVAL_CODE2 8'h04
`define HKADC_INTERVAL_CODE3 8'h10
`define HKADC_BAT_LSB_UV 15000

// ****************************************
// Timing
// ****************************************
`define HKADC_CLK_PERIOD_NS 10
`define HKADC_TICK_PERIOD_NS 1000000

`endif

// ---- common/hkadc_pkg.sv ----
// Purpose: Types of the housekeeping converter sequencer.
// Assumes: Constants live in hkadc_cfg.svh.
// Notes: Nothing here is imported; users write hkadc_pkg::name.
package hkadc_pkg;

  typedef enum logic [2:0]
  {
    HKADC_IDLE = 3'b001,
    HKADC_REQ = 3'b010,
    HKADC_CONV = 3'b100
  } hkadc_state_t;

  typedef enum logic [1:0]
  {
    HKADC_FULL_POWER_MODE = 2'h0,
    HKADC_BATTERY_ACTIVE_MODE = 2'h1,
    HKADC_CORE_OFF_SLEEP_MODE = 2'h2
  } hkadc_mode_t;

endpackage

// ---- rtl/hkadc_sequencer.sv ----
// Purpose: Single and background conversions of battery, temperature and supply channels.
// Assumes: Register port and converter handshakes are synchronous to mclk_in.
// Notes: Channel 0 battery, 1 temperature, 2 supply; converter codes are 8 bits each.
// Notes on behaviour
// - No background temperature conversion until a temperature interval is programmed.
// - Background temperature result interrupts only when change exceeds temperature delta, when delta code is 7, or when no result has loaded yet.
// - Temperature start bit runs one conversion that interrupts on completion.
// - Temperature result loads only when a temperature interrupt is raised.
// - Temperature interrupt has no readable pending flag.
// - Temperature: full power both methods, battery active single, sleep background only.
// - Battery result is an 8-bit code at 15 mV per step.
// - Battery start bit runs one conversion; completion raises battery event with code.
// - Background battery code below threshold sets the low battery flag.
// - Low battery flag drives the monitor interrupt only when its enable is set.
// - Battery result loads only when the low battery flag becomes set.
// - Battery: full power both methods, battery active single, sleep background only.
// - Supply start bit runs one conversion that interrupts with the supply code.
// - No background supply conversion until a supply interval is programmed.
// - Background supply change beyond supply delta sets the supply change flag.
// - Supply change flag drives the monitor interrupt only when its enable is set.
// - Each start bit clears when the converter accepts the request.
// - Battery active mode allows single supply conversions only.
`timescale 1ns/100ps
`include "hkadc_cfg.svh"

module hkadc_sequencer
#(
  parameter int TICK_CYCLES = `HKADC_TICK_PERIOD_NS / `HKADC_CLK_PERIOD_NS,
  parameter int CODE_W = 8
)
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic [1:0] power_mode_in,
  output logic [2:0] conv_req_out,
  input wire logic [2:0] conv_ack_in,
  input wire logic [2:0] conv_done_in,
  input wire logic [3*CODE_W-1:0] conv_code_in,
  output logic adc_irq_out,
  output logic psm_irq_out
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] start_reg;
  logic [7:0] pm_enable_reg;
  logic [7:0] delta_reg;
  logic [7:0] flags_reg;
  logic [7:0] interval_reg;
  logic [7:0] bat_thresh_reg;
  logic [CODE_W-1:0] result_reg [3];
  logic [CODE_W-1:0] ref_reg [3];
  logic [2:0] ref_valid_reg;
  logic [2:0] bg_pend_reg;
  logic [2:0] kind_bg_reg;
  logic [7:0] per_cnt_reg [3];
  hkadc_pkg::hkadc_state_t state_reg [3];
  logic [TICK_W-1:0] tick_cnt_reg;
  logic tick_reg;

  // ****************************************
  // Decode
  // ****************************************
  wire wr_start = sfr_wr_in && (sfr_addr_in == `HKADC_ADDR_START);
  wire wr_enable = sfr_wr_in && (sfr_addr_in == `HKADC_ADDR_PM_ENABLE);
  wire wr_delta = sfr_wr_in && (sfr_addr_in == `HKADC_ADDR_DELTA);
  wire wr_flags = sfr_wr_in && (sfr_addr_in == `HKADC_ADDR_PM_FLAGS);
  wire wr_interval = sfr_wr_in && (sfr_addr_in == `HKADC_ADDR_INTERVAL);
  wire wr_thresh = sfr_wr_in && (sfr_addr_in == `HKADC_ADDR_BAT_THRESH);
  wire single_ok = power_mode_in != hkadc_pkg::HKADC_CORE_OFF_SLEEP_MODE;
  wire bg_ok = power_mode_in != hkadc_pkg::HKADC_BATTERY_ACTIVE_MODE;
  wire [2:0] accept_w;
  wire [2:0] done_w;
  wire [2:0] exceed_w;
  wire [2:0] report_w;
  wire [2:0] launch_w;
  wire [CODE_W-1:0] code_w [3];
  wire [CODE_W-1:0] diff_w [3];
  wire [2:0] dcode_w [3];
  assign dcode_w[`HKADC_CH_BAT] = `HKADC_DIFF_NEVER;
  assign dcode_w[`HKADC_CH_TEMP] = delta_reg[`HKADC_DIFF_TEMP_LSB +: `HKADC_DIFF_W];
  assign dcode_w[`HKADC_CH_VSW] = delta_reg[`HKADC_DIFF_VSW_LSB +: `HKADC_DIFF_W];

  // ****************************************
  // Interval tick divider
  // ****************************************
  wire tick_wrap = tick_cnt_reg == TICK_W'(TICK_CYCLES - 1);
  wire [TICK_W-1:0] tick_cnt_next = tick_wrap ? '0 : tick_cnt_reg + TICK_W'(1);

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_wrap;
    end
  end

  // ****************************************
  // Per-channel sequencing
  // ****************************************
  for (genvar ch = 0; ch < 3; ch++)
  begin : g_ch
    wire [`HKADC_PER_W-1:0] per = interval_reg[ch*`HKADC_PER_W +: `HKADC_PER_W];
    wire [7:0] lim = (per == 2'h1) ? `HKADC_INTERVAL_CODE1 :
                     (per == 2'h2) ? `HKADC_INTERVAL_CODE2 : `HKADC_INTERVAL_CODE3;
    wire per_hit = tick_reg && (per != 2'h0) && (per_cnt_reg[ch] + 8'h01 >= lim);
    wire [7:0] per_cnt_next = (per == 2'h0) ? 8'h00 :
                              !tick_reg ? per_cnt_reg[ch] :
                              per_hit ? 8'h00 : per_cnt_reg[ch] + 8'h01;
    wire want_single = start_reg[ch] && single_ok;
    wire idle = state_reg[ch] == hkadc_pkg::HKADC_IDLE;
    wire dc_never = dcode_w[ch] == `HKADC_DIFF_NEVER;
    wire dc_always = dcode_w[ch] == `HKADC_DIFF_ALWAYS;
    assign launch_w[ch] = idle && (want_single || (bg_pend_reg[ch] && bg_ok));
    assign accept_w[ch] = (state_reg[ch] == hkadc_pkg::HKADC_REQ) && conv_ack_in[ch];
    assign done_w[ch] = (state_reg[ch] == hkadc_pkg::HKADC_CONV) && conv_done_in[ch];
    assign code_w[ch] = conv_code_in[ch*CODE_W +: CODE_W];
    assign diff_w[ch] = (code_w[ch] >= ref_reg[ch]) ? code_w[ch] - ref_reg[ch]
                                                     : ref_reg[ch] - code_w[ch];
    assign exceed_w[ch] = !ref_valid_reg[ch] || dc_always ||
                          (!dc_never && (diff_w[ch] > CODE_W'(dcode_w[ch])));
    if (ch == `HKADC_CH_BAT)
    begin : g_bat
      assign report_w[ch] = done_w[ch] &&
                            (!kind_bg_reg[ch] || (code_w[ch] < bat_thresh_reg));
    end
    else
    begin : g_delta
      assign report_w[ch] = done_w[ch] && (!kind_bg_reg[ch] || exceed_w[ch]);
    end

    hkadc_pkg::hkadc_state_t state_next;
    always_comb
    begin
      state_next = state_reg[ch];
      unique case (state_reg[ch])
        hkadc_pkg::HKADC_IDLE:
          if (launch_w[ch])
            state_next = hkadc_pkg::HKADC_REQ;
        hkadc_pkg::HKADC_REQ:
          if (conv_ack_in[ch])
            state_next = hkadc_pkg::HKADC_CONV;
        hkadc_pkg::HKADC_CONV:
          if (conv_done_in[ch])
            state_next = hkadc_pkg::HKADC_IDLE;
        default:
          state_next = hkadc_pkg::HKADC_IDLE;
      endcase
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
      if (sys_rst_in)
      begin
        state_reg[ch] <= hkadc_pkg::HKADC_IDLE;
        kind_bg_reg[ch] <= 1'b0;
        bg_pend_reg[ch] <= 1'b0;
        per_cnt_reg[ch] <= 8'h00;
        result_reg[ch] <= `HKADC_REG_RESET;
        ref_reg[ch] <= `HKADC_REG_RESET;
        ref_valid_reg[ch] <= 1'b0;
      end
      else
      begin
        state_reg[ch] <= state_next;
        per_cnt_reg[ch] <= per_cnt_next;
        if (launch_w[ch])
          kind_bg_reg[ch] <= !want_single;
        if (per_hit)
          bg_pend_reg[ch] <= 1'b1;
        else if (launch_w[ch] && !want_single)
          bg_pend_reg[ch] <= 1'b0;
        if (report_w[ch])
        begin
          result_reg[ch] <= code_w[ch];
          ref_reg[ch] <= code_w[ch];
          ref_valid_reg[ch] <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Software registers and flags
  // ****************************************
  wire [7:0] accept_single = {5'h00, accept_w & ~kind_bg_reg};
  wire [7:0] start_next = (start_reg & ~accept_single) |
                          (wr_start ? (sfr_wdata_in & `HKADC_START_MASK) : 8'h00);
  wire [7:0] flag_set = {6'h00, report_w[`HKADC_CH_BAT],
                         report_w[`HKADC_CH_VSW] && kind_bg_reg[`HKADC_CH_VSW]};
  wire [7:0] flags_kept = wr_flags ? (flags_reg & sfr_wdata_in) : flags_reg;
  wire [7:0] flags_next = (flags_kept | flag_set) & `HKADC_FLAG_MASK;
  wire adc_irq_next = report_w[`HKADC_CH_TEMP] ||
                      (report_w[`HKADC_CH_VSW] && !kind_bg_reg[`HKADC_CH_VSW]);
  wire psm_irq_next = |(flags_reg & pm_enable_reg & `HKADC_FLAG_MASK);
  wire [7:0] rdata_next =
    (sfr_addr_in == `HKADC_ADDR_TEMP_RESULT) ? result_reg[`HKADC_CH_TEMP] :
    (sfr_addr_in == `HKADC_ADDR_START) ? start_reg :
    (sfr_addr_in == `HKADC_ADDR_BAT_RESULT) ? result_reg[`HKADC_CH_BAT] :
    (sfr_addr_in == `HKADC_ADDR_PM_ENABLE) ? pm_enable_reg :
    (sfr_addr_in == `HKADC_ADDR_VSW_RESULT) ? result_reg[`HKADC_CH_VSW] :
    (sfr_addr_in == `HKADC_ADDR_DELTA) ? delta_reg :
    (sfr_addr_in == `HKADC_ADDR_PM_FLAGS) ? flags_reg :
    (sfr_addr_in == `HKADC_ADDR_INTERVAL) ? interval_reg :
    (sfr_addr_in == `HKADC_ADDR_BAT_THRESH) ? bat_thresh_reg : 8'h00;

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      start_reg <= `HKADC_REG_RESET;
      pm_enable_reg <= `HKADC_REG_RESET;
      delta_reg <= `HKADC_REG_RESET;
      flags_reg <= `HKADC_REG_RESET;
      interval_reg <= `HKADC_REG_RESET;
      bat_thresh_reg <= `HKADC_REG_RESET;
      adc_irq_out <= 1'b0;
      psm_irq_out <= 1'b0;
      sfr_rdata_out <= 8'h00;
      conv_req_out <= 3'h0;
    end
    else
    begin
      start_reg <= start_next;
      if (wr_enable)
        pm_enable_reg <= sfr_wdata_in & `HKADC_FLAG_MASK;
      if (wr_delta)
        delta_reg <= sfr_wdata_in;
      flags_reg <= flags_next;
      if (wr_interval)
        interval_reg <= sfr_wdata_in;
      if (wr_thresh)
        bat_thresh_reg <= sfr_wdata_in;
      adc_irq_out <= adc_irq_next;
      psm_irq_out <= psm_irq_next;
      sfr_rdata_out <= rdata_next;
      conv_req_out <= launch_w | ({3{1'b1}} & ~accept_w & conv_req_out);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_temp_bg_period: assert property ($rose(bg_pend_reg[`HKADC_CH_TEMP]) |->
    $past(interval_reg[`HKADC_CH_TEMP*2 +: 2]) != 2'h0)
    else $error("temperature background started without interval");
  a_vsw_bg_period: assert property ($rose(bg_pend_reg[`HKADC_CH_VSW]) |->
    $past(interval_reg[`HKADC_CH_VSW*2 +: 2]) != 2'h0)
    else $error("supply background started without interval");
  a_temp_delta_irq: assert property (done_w[`HKADC_CH_TEMP] && kind_bg_reg[`HKADC_CH_TEMP]
    && ref_valid_reg[`HKADC_CH_TEMP] && dcode_w[`HKADC_CH_TEMP] != 3'h0
    && diff_w[`HKADC_CH_TEMP] > 8'(dcode_w[`HKADC_CH_TEMP]) |=> adc_irq_out
    && result_reg[`HKADC_CH_TEMP] == $past(code_w[`HKADC_CH_TEMP]))
    else $error("temperature delta did not interrupt");
  a_temp_single_irq: assert property (done_w[`HKADC_CH_TEMP] && !kind_bg_reg[`HKADC_CH_TEMP]
    |=> adc_irq_out)
    else $error("single temperature conversion gave no interrupt");
  a_temp_result_hold: assert property (!report_w[`HKADC_CH_TEMP]
    |=> $stable(result_reg[`HKADC_CH_TEMP]))
    else $error("temperature result changed without interrupt");
  a_mode_bg_gate: assert property (launch_w[`HKADC_CH_VSW] && !start_reg[`HKADC_CH_VSW]
    |-> power_mode_in != hkadc_pkg::HKADC_BATTERY_ACTIVE_MODE)
    else $error("supply background ran in battery active mode");
  a_mode_single_gate: assert property (state_reg[`HKADC_CH_TEMP] == hkadc_pkg::HKADC_REQ
    && !kind_bg_reg[`HKADC_CH_TEMP] |-> $past(power_mode_in)
    != hkadc_pkg::HKADC_CORE_OFF_SLEEP_MODE || $past(state_reg[`HKADC_CH_TEMP])
    == hkadc_pkg::HKADC_REQ)
    else $error("single temperature ran in sleep mode");
  a_low_bat_flag: assert property (done_w[`HKADC_CH_BAT] && kind_bg_reg[`HKADC_CH_BAT]
    && code_w[`HKADC_CH_BAT] < bat_thresh_reg |=> flags_reg[`HKADC_FLAG_BAT_BIT]
    && result_reg[`HKADC_CH_BAT] == $past(code_w[`HKADC_CH_BAT]))
    else $error("low battery flag not set");
  a_bat_result_hold: assert property ($changed(result_reg[`HKADC_CH_BAT])
    |-> flags_reg[`HKADC_FLAG_BAT_BIT])
    else $error("battery result changed without flag");
  a_psm_irq_gate: assert property (psm_irq_out |-> $past(flags_reg[`HKADC_FLAG_BAT_BIT]
    && pm_enable_reg[`HKADC_FLAG_BAT_BIT]) || $past(flags_reg[`HKADC_FLAG_VSW_BIT]
    && pm_enable_reg[`HKADC_FLAG_VSW_BIT]))
    else $error("monitor interrupt without enabled flag");
  a_vsw_flag_delta: assert property (done_w[`HKADC_CH_VSW] && kind_bg_reg[`HKADC_CH_VSW]
    && exceed_w[`HKADC_CH_VSW] |=> flags_reg[`HKADC_FLAG_VSW_BIT])
    else $error("supply change flag not set");
  a_start_clear: assert property (accept_w[`HKADC_CH_BAT] && !kind_bg_reg[`HKADC_CH_BAT]
    && !wr_start |=> !start_reg[`HKADC_CH_BAT] ##1 !conv_req_out[`HKADC_CH_BAT])
    else $error("start bit not cleared on accept");

  c_temp_single: cover property (done_w[`HKADC_CH_TEMP] && !kind_bg_reg[`HKADC_CH_TEMP]);
  c_bat_low: cover property (report_w[`HKADC_CH_BAT] && kind_bg_reg[`HKADC_CH_BAT]);
  c_vsw_change: cover property (report_w[`HKADC_CH_VSW] && kind_bg_reg[`HKADC_CH_VSW]);

endmodule

// ---- tb/hkadc_conv_model.sv ----
// Purpose: Behavioural converters for the battery, temperature and supply channels.
// Assumes: Requests are sampled on the rising edge; answers change 1 ns after it.
// Notes: Outside its done cycle a code line carries a pattern that changes every cycle.
`timescale 1ns/100ps
module hkadc_conv_model
(
  input wire logic mclk_in,
  input wire logic slow_in,
  input wire logic [2:0] conv_req_in,
  input wire logic [23:0] code_set_in,
  output logic [2:0] conv_ack_out,
  output logic [2:0] conv_done_out,
  output logic [23:0] conv_code_out
);
  for (genvar ch = 0; ch < 3; ch++)
  begin : g_ch
    logic ack_reg = 1'b0;
    logic done_reg = 1'b0;
    logic [7:0] val_reg = 8'h00;
    logic [7:0] junk_reg = 8'h5a;
    assign conv_ack_out[ch] = ack_reg;
    assign conv_done_out[ch] = done_reg;
    assign conv_code_out[8*ch+:8] = done_reg ? val_reg : junk_reg;
    always @(posedge mclk_in)
      junk_reg <= junk_reg + 8'h3b;
    // A slow converter leaves the request waiting before it accepts it.
    initial
      forever
      begin
        @(posedge mclk_in);
        if (conv_req_in[ch] === 1'b1)
        begin
          repeat (slow_in ? 3 : 0) @(posedge mclk_in);
          #1 ack_reg = 1'b1;
          @(posedge mclk_in);
          #1 ack_reg = 1'b0;
          repeat (slow_in ? 6 : 1) @(posedge mclk_in);
          #1 val_reg = code_set_in[8*ch+:8];
          done_reg = 1'b1;
          @(posedge mclk_in);
          #1 done_reg = 1'b0;
        end
      end
  end
endmodule

// ---- tb/hkadc_sequencer_tb.sv ----
// Purpose: Self-checking bench of the housekeeping converter sequencer.
// Assumes: Tick shortened to 4 clocks; interval code 1 is one tick.
// Notes: A reference model judges every completed conversion.
`timescale 1ns/100ps
`include "hkadc_cfg.svh"
module hkadc_sequencer_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [1:0] mode = 2'h0;
  logic slow = 1'b0;
  logic [23:0] code_set = 24'h000000;
  logic [7:0] rdata;
  logic [2:0] req, ack, done;
  logic [23:0] code;
  logic adc_irq, psm_irq;
  logic [31:0] seed = 32'hcf28;
  logic [7:0] regs[10] = '{8'hd7, 8'hd8, 8'hdf, 8'hec, 8'hef, 8'hf3, 8'hf8, 8'hf9, 8'hfa, 8'h00};
  logic [7:0] dtab[4] = '{8'h11, 8'h3f, 8'h00, 8'h2a};
  int num_errors = 0;
  int n_checks = 0;
  int res[3], refv[3], ref_ok[3], single[3], done_cnt[3];
  int flags = 0, en = 0, dlt = 0, thr = 0, win = 0, exp_pulse = 0, saw = 0, busy = 0;

  always #5 clk = ~clk;

  hkadc_sequencer #(.TICK_CYCLES(4)) i_hkadc_sequencer
  (
    .mclk_in(clk), .sys_rst_in(rst), .sfr_addr_in(addr), .sfr_wr_in(wr),
    .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .power_mode_in(mode),
    .conv_req_out(req), .conv_ack_in(ack), .conv_done_in(done), .conv_code_in(code),
    .adc_irq_out(adc_irq), .psm_irq_out(psm_irq)
  );
  hkadc_conv_model i_hkadc_conv_model
  (
    .mclk_in(clk), .slow_in(slow), .conv_req_in(req), .code_set_in(code_set),
    .conv_ack_out(ack), .conv_done_out(done), .conv_code_out(code)
  );

  // ****************************************
  // Reference model and checks
  // ****************************************
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic judge(input int ch, input int c);
    int d;
    int rep;
    d = (ch == 1) ? (dlt >> 3) & 7 : dlt & 7;
    rep = single[ch] || !ref_ok[ch] || d == 7 || (d != 0 && (c > refv[ch] + d || c < refv[ch] - d));
    if (ch == 0)
      rep = single[0] || c < thr;
    if (rep)
    begin
      res[ch] = c;
      refv[ch] = c;
      ref_ok[ch] = 1;
      flags |= (ch == 0) ? 2 : (ch == 2 && !single[2]) ? 1 : 0;
    end
    if (ch != 0)
    begin
      // Temperature and supply can finish on one edge; the shared pulse is then the OR of both.
      if (win != 2)
        exp_pulse = 0;
      win = 2;
      saw = 0;
      exp_pulse |= (ch == 1) ? rep : single[2];
    end
    single[ch] = 0;
    busy--;
    done_cnt[ch]++;
  endtask

  always @(posedge clk)
  begin
    if (win > 0)
    begin
      if (adc_irq === 1'b1)
        saw = 1;
      win--;
      if (win == 0)
        check({7'h00, saw == 1}, {7'h00, exp_pulse == 1});
    end
    for (int ch = 0; ch < 3; ch++)
    begin
      busy += (ack[ch] === 1'b1);
      if (done[ch] === 1'b1)
        judge(ch, code[8*ch+:8]);
    end
  end

  // ****************************************
  // Register port and waits
  // ****************************************
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    wr = 1'b1;
    wdata = d;
    @(posedge clk);
    #1 wr = 1'b0;
    case (a)
      `HKADC_ADDR_PM_ENABLE: en = d & 3;
      `HKADC_ADDR_DELTA: dlt = d;
      `HKADC_ADDR_BAT_THRESH: thr = d;
      `HKADC_ADDR_PM_FLAGS: flags &= d;
      `HKADC_ADDR_START: for (int i = 0; i < 3; i++) single[i] |= d[i];
      default: ;
    endcase
  endtask

  task automatic rd_chk(input logic [7:0] a, input int e);
    @(posedge clk);
    #1 addr = a;
    @(posedge clk);
    #1 check(rdata, e[7:0]);
  endtask

  task automatic wait_done(input int ch, input int n);
    for (int i = 0; i < 400 && done_cnt[ch] < n; i++)
      @(posedge clk);
    if (done_cnt[ch] < n)
    begin
      num_errors++;
      complete_run();
    end
  endtask

  task automatic chk_all();
    int q;
    q = 0;
    for (int i = 0; i < 500 && q < 4; i++)
    begin
      @(posedge clk);
      q = (req === 3'b000 && win == 0 && busy == 0 && single.sum() == 0) ? q + 1 : 0;
    end
    if (q < 4)
    begin
      num_errors++;
      complete_run();
    end
    rd_chk(`HKADC_ADDR_BAT_RESULT, res[0]);
    rd_chk(`HKADC_ADDR_TEMP_RESULT, res[1]);
    rd_chk(`HKADC_ADDR_VSW_RESULT, res[2]);
    rd_chk(`HKADC_ADDR_PM_FLAGS, flags);
    check({7'h00, psm_irq}, {7'h00, (flags & en) != 0});
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    int n;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    repeat (60)
    begin
      @(posedge clk);
      check({5'h00, req}, 8'h00);
    end
    foreach (regs[i])
      rd_chk(regs[i], 0);
    wr_reg(8'h55, 8'hff);
    wr_reg(`HKADC_ADDR_TEMP_RESULT, 8'hff);
    wr_reg(`HKADC_ADDR_PM_ENABLE, 8'hff);
    rd_chk(8'h55, 0);
    rd_chk(`HKADC_ADDR_TEMP_RESULT, 0);
    rd_chk(`HKADC_ADDR_PM_ENABLE, 3);
    wr_reg(`HKADC_ADDR_PM_ENABLE, 8'h00);
    for (int ch = 0; ch < 3; ch++)
    begin
      seed = xs(seed);
      code_set[8*ch+:8] = seed[7:0];
      slow = ch[0];
      n = done_cnt[ch] + 1;
      wr_reg(`HKADC_ADDR_START, 8'h01 << ch);
      wait_done(ch, n);
      rd_chk(`HKADC_ADDR_START, 0);
      chk_all();
    end
    wr_reg(`HKADC_ADDR_PM_ENABLE, 8'h02);
    chk_all();
    wr_reg(`HKADC_ADDR_PM_FLAGS, 8'h00);
    chk_all();
    mode = 2'h2;
    n = done_cnt[1] + 1;
    wr_reg(`HKADC_ADDR_START, 8'h02);
    repeat (30)
    begin
      @(posedge clk);
      check({7'h00, req[1]}, 8'h00);
    end
    #1 mode = 2'h0;
    wait_done(1, n);
    wr_reg(`HKADC_ADDR_BAT_THRESH, 8'h80);
    wr_reg(`HKADC_ADDR_PM_ENABLE, 8'h03);
    mode = 2'h1;
    n = done_cnt[1] + 1;
    wr_reg(`HKADC_ADDR_START, 8'h02);
    wait_done(1, n);
    wr_reg(`HKADC_ADDR_DELTA, dtab[0]);
    wr_reg(`HKADC_ADDR_INTERVAL, 8'h15);
    repeat (60)
    begin
      @(posedge clk);
      check({5'h00, req}, 8'h00);
    end
    for (int k = 0; k < 4; k++)
    begin
      #1 mode = (k < 2) ? 2'h0 : 2'h2;
      slow = k[0];
      wr_reg(`HKADC_ADDR_DELTA, dtab[k]);
      repeat (4)
      begin
        seed = xs(seed);
        code_set = {8'h90 ^ {5'h00, seed[2:0]}, 8'h60 ^ {5'h00, seed[10:8]}, seed[23:16]};
        wait_done(1, done_cnt[1] + 1);
      end
    end
    wr_reg(`HKADC_ADDR_INTERVAL, 8'h00);
    chk_all();
    // Battery every 4 ticks (16 clocks), temperature every 16 ticks (64 clocks).
    wr_reg(`HKADC_ADDR_INTERVAL, 8'h0e);
    wait_done(0, done_cnt[0] + 1);
    n = done_cnt[0];
    repeat (56) @(posedge clk);
    check(8'(done_cnt[0] - n), 8'h03);
    wait_done(1, done_cnt[1] + 1);
    n = done_cnt[1];
    repeat (120) @(posedge clk);
    check(8'(done_cnt[1] - n), 8'h01);
    wr_reg(`HKADC_ADDR_INTERVAL, 8'h00);
    chk_all();
    complete_run();
  end
endmodule
